// File: hw/sec_top.sv
// serial encoder command and trigger front end with apb registers
// Functional notes
// - the six-bit variant sends one of four request codes to the encoder.
// - sample mode 0 repeats once per selected clock tick, 1 samples once.
// - repeated sampling runs on every tick that finds it idle, only while enable is 1.
// - single sampling does one transaction, then hardware clears enable.
// - the done flag reads 0 while receiving and 1 when reception is over.
// - software writes never change the done flag.
// - motor code zero reads 16 multi-turn and 23 single-turn bits.
// - motor code 00D8 reads 23 single-turn bits and an error code.
// - the low position word is read-only.
// - the low position word layout follows the configured protocol and, for the 16-bit variant, the request code.
// - for biss-c the low 32 position bits fill bits 31 to 0.
// - the top bit of the upper data word flags an encoder timeout.
`timescale 1ns/10ps
`include "sec_consts.svh"
module sec_top
    import sec_pkg::*;
#(
    parameter int HALF_CYC = `SEC_HALF_CYC,
    parameter int TO_BITS  = `SEC_TO_BITS
)(
    // clock and reset
    input  wire logic              clk_i,
    input  wire logic              rst_b_i,
    // apb slave
    input  wire logic              psel_i,
    input  wire logic              penable_i,
    input  wire logic              pwrite_i,
    input  wire logic [`SEC_AW-1:0] paddr_i,
    input  wire logic [31:0]       pwdata_i,
    output logic      [31:0]       prdata_o,
    output logic                   pready_o,
    output logic                   pslverr_o,
    // selected phase or servo tick, same clock domain
    input  wire logic              sample_tick_i,
    // encoder link
    input  wire logic              enc_di_i,
    output logic                   enc_clk_o,
    output logic                   enc_do_o,
    // interrupt
    output logic                   irq_o
);
    sec_state_e  st, next_st;
    logic [15:0] code, next_code;
    logic [9:0]  low, next_low;
    logic        mode, next_mode, en, next_en, done, next_done;
    logic [1:0]  proto, next_proto, stat, next_stat, mask, next_mask;
    logic [31:0] pos_lo, next_pos_lo, pos_hi, next_pos_hi;
    logic [39:0] sr, next_sr;
    logic [15:0] cmd, next_cmd;
    logic [5:0]  cnt, next_cnt;
    logic [7:0]  to_cnt, next_to_cnt;
    logic [15:0] half, next_half;
    logic        tout, next_tout, next_clk, next_do;
    logic [31:0] next_prdata;
    logic        next_pready, next_pslverr, next_irq;
    logic        di_m, di_s;
    logic        start, bit_edge, wr_acc;
    logic [5:0]  rx_len;
    logic [4:0]  cmd_len;
    logic [15:0] cmd_load;

    // two flops: the encoder answers from outside our clock
    always_ff @(posedge clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            di_m <= 1'b0;
            di_s <= 1'b0;
        end
        else
        begin
            di_m <= enc_di_i;
            di_s <= di_m;
        end
    end

    assign wr_acc = psel_i & penable_i & pwrite_i & pready_o;
    // a tick that arrives mid-frame is dropped, not queued
    assign start = (st == SEC_IDLE) & en
                 & (mode | sample_tick_i);
    assign bit_edge = (half == 16'h0000) & ~enc_clk_o;

    always_comb
    begin
        cmd_len = `SEC_LEN_CMD6;
        cmd_load = {code[`SEC_F_CODE6_HI-`SEC_F_CODE_LO:0], 10'h000};
        rx_len = low[`SEC_F_WIDTH_HI:0];
        if (proto == SEC_P_CMD16)
        begin
            cmd_len = `SEC_LEN_CMD16;
            cmd_load = code;
            case (code)
                `SEC_CODE16_POS: rx_len = `SEC_LEN_FULL;
                `SEC_CODE16_ST:  rx_len = `SEC_LEN_ST;
                default:         rx_len = `SEC_LEN_ACK;
            endcase
        end
        else if (proto == SEC_P_BISS)
        begin
            cmd_len = 5'h00;
        end
    end

    always_comb
    begin
        next_st = st;
        next_code = code;
        next_low = low;
        next_mode = mode;
        next_en = en;
        next_done = done;
        next_proto = proto;
        next_stat = stat;
        next_mask = mask;
        next_pos_lo = pos_lo;
        next_pos_hi = pos_hi;
        next_sr = sr;
        next_cmd = cmd;
        next_cnt = cnt;
        next_to_cnt = to_cnt;
        next_tout = tout;
        next_half = (half == 16'h0000) ? 16'(HALF_CYC - 1) : half - 16'h0001;
        next_clk = (half == 16'h0000) ? ~enc_clk_o : enc_clk_o;
        case (st)
            SEC_IDLE:
            begin
                next_half = 16'(HALF_CYC - 1);
                next_clk = 1'b1;
                if (start)
                begin
                    next_done = 1'b0;
                    next_sr = 40'h00_0000_0000;
                    next_tout = 1'b0;
                    next_cmd = cmd_load;
                    next_cnt = {1'b0, cmd_len};
                    next_to_cnt = 8'(TO_BITS);
                    next_st = (cmd_len == 5'h00) ? SEC_WAIT : SEC_CMD;
                end
            end
            SEC_CMD:
                if (bit_edge)
                begin
                    next_cmd = {cmd[14:0], 1'b0};
                    next_cnt = cnt - 6'h01;
                    if (cnt == 6'h01)
                        next_st = SEC_WAIT;
                end
            SEC_WAIT:
                if (bit_edge)
                begin
                    if (di_s)
                    begin
                        next_cnt = rx_len;
                        next_st = SEC_RX;
                    end
                    else if (to_cnt == 8'h01)
                    begin
                        next_tout = 1'b1;
                        next_st = SEC_LATCH;
                    end
                    else
                        next_to_cnt = to_cnt - 8'h01;
                end
            SEC_RX:
                if (bit_edge)
                begin
                    next_sr = {sr[38:0], di_s};
                    next_cnt = cnt - 6'h01;
                    if (cnt == 6'h01)
                        next_st = SEC_LATCH;
                end
            SEC_LATCH:
            begin
                next_clk = 1'b1;
                next_done = 1'b1;
                next_pos_lo = sr[31:0];
                next_pos_hi = {tout, 23'h00_0000, sr[39:32]};
                if (proto == SEC_P_CMD16 && code == `SEC_CODE16_ST)
                begin
                    next_pos_lo = {9'h000, sr[30:8]};
                    next_pos_hi = {tout, 23'h00_0000, sr[7:0]};
                end
                else if (proto == SEC_P_CMD16)
                    next_pos_hi = {tout, 24'h00_0000, sr[38:32]};
                next_stat[`SEC_ST_DONE] = 1'b1;
                next_stat[`SEC_ST_TOUT] = stat[`SEC_ST_TOUT] | tout;
                if (mode)
                    next_en = 1'b0;
                next_st = SEC_IDLE;
            end
            default:
                next_st = SEC_IDLE;
        endcase
        if (wr_acc)
        begin
            case (paddr_i)
                `SEC_OFS_CTRL:
                begin
                    // done bit is not writable
                    next_code = pwdata_i[`SEC_F_CODE_HI:`SEC_F_CODE_LO];
                    next_mode = pwdata_i[`SEC_F_MODE];
                    next_en = pwdata_i[`SEC_F_EN];
                    next_low = pwdata_i[`SEC_F_LOW_HI:0];
                end
                `SEC_OFS_PROTO: next_proto = pwdata_i[1:0];
                // hardware set wins over the one-to-clear
                `SEC_OFS_STAT:  next_stat = stat & ~pwdata_i[1:0];
                `SEC_OFS_MASK:  next_mask = pwdata_i[1:0];
                default:        next_mask = mask;
            endcase
        end
        if (st == SEC_LATCH)
            next_stat = next_stat | {tout, 1'b1};
        next_do = (next_st == SEC_CMD) & next_cmd[15];
        next_irq = |(next_stat & next_mask);
    end

    // apb: data and ready registered in setup, zero wait states
    always_comb
    begin
        next_pready = psel_i & ~penable_i;
        next_pslverr = 1'b0;
        next_prdata = 32'h0000_0000;
        if (psel_i & ~penable_i)
        begin
            case (paddr_i)
                `SEC_OFS_CTRL:
                    next_prdata = {code, 2'b00, mode, en, 1'b0, done, low};
                `SEC_OFS_POS_LO: next_prdata = pos_lo;
                `SEC_OFS_POS_HI: next_prdata = pos_hi;
                `SEC_OFS_PROTO:  next_prdata = {30'h0000_0000, proto};
                `SEC_OFS_STAT:   next_prdata = {30'h0000_0000, stat};
                `SEC_OFS_MASK:   next_prdata = {30'h0000_0000, mask};
                default:         next_pslverr = 1'b1;
            endcase
        end
    end

    always_ff @(posedge clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            st <= SEC_IDLE;
            {code, mode, en, low} <= 28'h000_0000;
            done <= 1'b1;
            proto <= SEC_P_CMD6;
            stat <= 2'b00;
            mask <= 2'b00;
            pos_lo <= 32'h0000_0000;
            pos_hi <= 32'h0000_0000;
            sr <= 40'h00_0000_0000;
            cmd <= 16'h0000;
            cnt <= 6'h00;
            to_cnt <= 8'h00;
            half <= 16'h0000;
            tout <= 1'b0;
            enc_clk_o <= 1'b1;
            enc_do_o <= 1'b0;
            irq_o <= 1'b0;
            prdata_o <= 32'h0000_0000;
            pready_o <= 1'b0;
            pslverr_o <= 1'b0;
        end
        else
        begin
            st <= next_st;
            {code, mode, en, low} <= {next_code, next_mode, next_en, next_low};
            done <= next_done;
            proto <= next_proto;
            stat <= next_stat;
            mask <= next_mask;
            pos_lo <= next_pos_lo;
            pos_hi <= next_pos_hi;
            sr <= next_sr;
            cmd <= next_cmd;
            cnt <= next_cnt;
            to_cnt <= next_to_cnt;
            half <= next_half;
            tout <= next_tout;
            enc_clk_o <= next_clk;
            enc_do_o <= next_do;
            irq_o <= next_irq;
            prdata_o <= next_prdata;
            pready_o <= next_pready;
            pslverr_o <= next_pslverr;
        end
    end

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_b_i);
    sequence s_start;
        st == SEC_IDLE ##0 start;
    endsequence
    sequence s_latch;
        st == SEC_LATCH;
    endsequence

    AST_DONE_LOW_BUSY: assert property (
        st inside {SEC_CMD, SEC_WAIT, SEC_RX} |-> !done)
        else $error("done set during a frame");
    AST_DONE_START: assert property (
        s_start |=> !done ##1 !done)
        else $error("done not cleared at start");
    AST_ONE_SHOT: assert property (
        s_latch ##0 mode && !wr_acc |=> !en && st == SEC_IDLE && done)
        else $error("single sample left enable set");
    AST_NO_EN: assert property (
        !en |=> st != SEC_CMD && st != SEC_WAIT || $past(st) != SEC_IDLE)
        else $error("frame started with enable low");
    AST_REPEAT: assert property (
        st == SEC_IDLE && en && !mode && sample_tick_i
        |=> st inside {SEC_CMD, SEC_WAIT})
        else $error("tick did not start a frame");
    AST_DONE_RO: assert property (
        wr_acc && st == SEC_RX |=> !done)
        else $error("write changed done");
    AST_LO_RO: assert property (
        st != SEC_LATCH |=> $stable(pos_lo))
        else $error("low word changed without a frame");
    AST_BISS: assert property (
        s_latch ##0 proto == SEC_P_BISS |=> pos_lo == $past(sr[31:0]))
        else $error("biss low word mismatch");
    AST_TOUT: assert property (
        s_latch |=> pos_hi[`SEC_F_TOUT] == $past(tout)
                    && stat[`SEC_ST_TOUT] >= $past(tout))
        else $error("timeout flag not reported");
endmodule

// File: common/sec_consts.svh
// register map, field positions, reset values and timing counts
`ifndef SEC_CONSTS_SVH
`define SEC_CONSTS_SVH
`define SEC_AW          12
`define SEC_OFS_CTRL    12'h000
`define SEC_OFS_POS_LO  12'h004
`define SEC_OFS_POS_HI  12'h008
`define SEC_OFS_PROTO   12'h00C
`define SEC_OFS_STAT    12'h010
`define SEC_OFS_MASK    12'h014
`define SEC_CTL_RST     32'h0000_0000
`define SEC_F_CODE_HI   31
`define SEC_F_CODE_LO   16
`define SEC_F_CODE6_HI  21
`define SEC_F_MODE      13
`define SEC_F_EN        12
`define SEC_F_DONE      10
`define SEC_F_LOW_HI    9
`define SEC_F_WIDTH_HI  5
`define SEC_F_TOUT      31
`define SEC_ST_DONE     0
`define SEC_ST_TOUT     1
`define SEC_CODE6_POS   6'h07
`define SEC_CODE6_RST   6'h2A
`define SEC_CODE6_ADD   6'h38
`define SEC_CODE6_ADDR  6'h2D
`define SEC_CODE16_POS  16'h0000
`define SEC_CODE16_ST   16'h00D8
`define SEC_CODE16_ECLR 16'h0040
`define SEC_CODE16_MCLR 16'h0048
`define SEC_LEN_FULL    6'h27
`define SEC_LEN_ST      6'h1F
`define SEC_LEN_ACK     6'h08
`define SEC_LEN_CMD6    5'h06
`define SEC_LEN_CMD16   5'h10
`define SEC_CLK_NS      40
`define SEC_HALF_NS     1000
`define SEC_HALF_CYC    (`SEC_HALF_NS / `SEC_CLK_NS)
`define SEC_TO_BITS     64
`endif

// File: common/sec_pkg.sv
// types shared by the serial encoder front end
package sec_pkg;
    typedef enum logic [2:0] {
        SEC_IDLE  = 3'b000,
        SEC_CMD   = 3'b001,
        SEC_WAIT  = 3'b011,
        SEC_RX    = 3'b010,
        SEC_LATCH = 3'b110
    } sec_state_e;
    typedef enum logic [1:0] {
        SEC_P_CMD6  = 2'b00,
        SEC_P_CMD16 = 2'b01,
        SEC_P_BISS  = 2'b10
    } sec_proto_e;
endpackage

// File: dv/sec_enc_model.sv
// behavioural serial position encoder at the far end of the link
`timescale 1ns/10ps
module sec_enc_model #(
    parameter int IDLE_CYC = 12
)(
    // clock and link
    input  wire logic        clk_i,
    input  wire logic        enc_clk_i,
    input  wire logic        enc_do_i,
    // frame shape set by the bench
    input  wire logic [4:0]  cmd_len_i,
    input  wire logic [5:0]  rx_len_i,
    input  wire logic [39:0] data_i,
    input  wire logic        mute_i,
    // answer and observations
    output logic             enc_di_o,
    output logic      [15:0] cmd_o,
    output int               frames_o
);
    int nbit = 0;
    int idle = 0;
    initial
    begin
        enc_di_o = 1'b0;
        cmd_o = 16'h0000;
        frames_o = 0;
    end
    // new bit on the falling clock so it settles before the sampling rise
    always @(negedge enc_clk_i)
    begin
        nbit = nbit + 1;
        // command bit is taken here: it changes with the rising clock
        if (nbit <= cmd_len_i)
            cmd_o <= {cmd_o[14:0], enc_do_i};
        if (mute_i || nbit <= cmd_len_i)
            enc_di_o <= 1'b0;
        else if (nbit == cmd_len_i + 1)
            enc_di_o <= 1'b1;
        else if (nbit <= cmd_len_i + 1 + rx_len_i)
            enc_di_o <= data_i[rx_len_i + cmd_len_i + 1 - nbit];
    end
    // released line shows the inverse of its last level, not a held value
    always @(posedge clk_i)
    begin
        idle = enc_clk_i ? idle + 1 : 0;
        if (idle == IDLE_CYC && nbit > 0)
        begin
            frames_o <= frames_o + 1;
            nbit = 0;
            cmd_o <= mute_i ? 16'hFFFF : cmd_o;
            enc_di_o <= ~enc_di_o;
        end
    end
endmodule

// File: dv/serial_encoder_command_trigger_bench.sv
// self-checking bench for the serial encoder front end
`timescale 1ns/10ps
`include "sec_consts.svh"
module serial_encoder_command_trigger_bench;
    logic        clk_i = 1'b0;
    logic        rst_b_i = 1'b0;
    logic        psel = 1'b0;
    logic        pen = 1'b0;
    logic        pwr = 1'b0;
    logic [11:0] pa = 12'h000;
    logic [31:0] pwd = 32'h0000_0000;
    logic        tick = 1'b0;
    logic [4:0]  clen = 5'h00;
    logic [5:0]  rlen = 6'h00;
    logic [39:0] data = 40'h00_0000_0000;
    logic        mute = 1'b0;
    logic [31:0] prd;
    logic [31:0] r;
    logic [15:0] cmd;
    logic        prdy, perr, di, eclk, edo, irq;
    int          frames;
    int          mismatches = 0;
    int          tests_run = 0;
    always #20 clk_i = ~clk_i;
    // short bit period and start-bit wait keep the run brief
    sec_top #(.HALF_CYC(4), .TO_BITS(4)) u_sec_top (
        .clk_i(clk_i), .rst_b_i(rst_b_i), .psel_i(psel), .penable_i(pen),
        .pwrite_i(pwr), .paddr_i(pa), .pwdata_i(pwd), .prdata_o(prd),
        .pready_o(prdy), .pslverr_o(perr), .sample_tick_i(tick),
        .enc_di_i(di), .enc_clk_o(eclk), .enc_do_o(edo), .irq_o(irq));
    sec_enc_model u_sec_enc_model (
        .clk_i(clk_i), .enc_clk_i(eclk), .enc_do_i(edo), .cmd_len_i(clen),
        .rx_len_i(rlen), .data_i(data), .mute_i(mute), .enc_di_o(di),
        .cmd_o(cmd), .frames_o(frames));
    task automatic end_sim();
        $display("tests_run %0d mismatches %0d", tests_run, mismatches);
        if (mismatches == 0 && tests_run > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp)
        begin
            mismatches++;
            $display("wrong value at %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic apb(input logic w, input logic [11:0] a,
                       input logic [31:0] d);
        int n;
        psel <= 1'b1;
        pwr <= w;
        pa <= a;
        pwd <= d;
        @(posedge clk_i);
        pen <= 1'b1;
        for (n = 0; n < 20; n++)
        begin
            @(posedge clk_i);
            if (prdy === 1'b1)
                break;
        end
        if (n == 20)
        begin
            mismatches++;
            end_sim();
        end
        r = perr ? 32'hDEAD_0000 : prd;
        psel <= 1'b0;
        pen <= 1'b0;
        @(posedge clk_i);
    endtask
    task automatic frame(input logic [1:0] pr, input logic [31:0] ctl,
                         input int cl, input int rl, input logic [39:0] d);
        int n;
        clen <= cl[4:0];
        rlen <= rl[5:0];
        data <= d;
        apb(1'b1, `SEC_OFS_PROTO, {30'h0, pr});
        apb(1'b1, `SEC_OFS_CTRL, ctl);
        apb(1'b0, `SEC_OFS_CTRL, 32'h0000_0000);
        chk(r[`SEC_F_DONE], 1'b0);
        for (n = 0; n < 400 && r[`SEC_F_DONE] !== 1'b1; n++)
            apb(1'b0, `SEC_OFS_CTRL, 32'h0000_0000);
        chk(n < 400, 1'b1);
        if (n == 400)
            end_sim();
        chk(r[`SEC_F_EN], 1'b0);
        repeat (20) @(posedge clk_i);
    endtask
    task automatic t_reset();
        apb(1'b0, `SEC_OFS_CTRL, 32'h0000_0000);
        chk(r, 32'h0000_0400);
        apb(1'b1, `SEC_OFS_CTRL, 32'h0000_0000);
        apb(1'b0, `SEC_OFS_CTRL, 32'h0000_0000);
        chk(r, 32'h0000_0400);
        apb(1'b1, `SEC_OFS_POS_LO, 32'hFFFF_FFFF);
        apb(1'b0, `SEC_OFS_POS_LO, 32'h0000_0000);
        chk(r, 32'h0000_0000);
        apb(1'b0, 12'h020, 32'h0000_0000);
        chk(r, 32'hDEAD_0000);
        $display("test reset done");
    endtask
    task automatic t_six();
        logic [5:0]  codes [4] = '{6'h07, 6'h2A, 6'h38, 6'h2D};
        logic [39:0] d;
        int          f;
        for (int i = 0; i < 4; i++)
        begin
            f = frames;
            d = 40'hC3_9A5E_71F0 + i;
            frame(2'd0, {10'h0, codes[i], 10'h0C0, i[0] ? 6'd40 : 6'd32},
                  6, i[0] ? 40 : 32, d);
            chk(cmd[5:0], codes[i]);
            chk(frames - f, 1);
            apb(1'b0, `SEC_OFS_POS_LO, 32'h0000_0000);
            chk(r, d[31:0]);
        end
        $display("test six bit done");
    endtask
    task automatic t_motor();
        logic [39:0] d = 40'h5B_ED3C_B2E1;
        int          f;
        logic [31:0] ctl;
        frame(2'd1, 32'h0000_3000, 16, 39, d);
        chk(cmd, 16'h0000);
        apb(1'b0, `SEC_OFS_POS_LO, 32'h0000_0000);
        chk(r, d[31:0]);
        apb(1'b0, `SEC_OFS_POS_HI, 32'h0000_0000);
        chk(r[6:0], d[38:32]);
        frame(2'd1, 32'h00D8_3000, 16, 31, d);
        chk(cmd, 16'h00D8);
        apb(1'b0, `SEC_OFS_POS_LO, 32'h0000_0000);
        chk(r, {9'h0, d[30:8]});
        apb(1'b0, `SEC_OFS_POS_HI, 32'h0000_0000);
        chk(r[7:0], d[7:0]);
        for (int k = 0; k < 2; k++)
        begin
            f = frames;
            ctl = k ? 32'h0048_3000 : 32'h0040_3000;
            repeat (8) frame(2'd1, ctl, 16, 8, d);
            chk(frames - f, 8);
            chk(cmd, k ? 16'h0048 : 16'h0040);
        end
        $display("test motor done");
    endtask
    task automatic t_biss();
        frame(2'd2, 32'h0000_3028, 0, 40, 40'h9E_8765_4321);
        apb(1'b0, `SEC_OFS_POS_LO, 32'h0000_0000);
        chk(r, 32'h8765_4321);
        apb(1'b0, `SEC_OFS_POS_HI, 32'h0000_0000);
        chk(r & 32'h8000_00FF, 32'h0000_009E);
        $display("test biss done");
    endtask
    task automatic t_repeat();
        int f = frames;
        apb(1'b1, `SEC_OFS_CTRL, 32'h0000_1010);
        repeat (100) @(posedge clk_i);
        chk(frames - f, 0);
        for (int k = 0; k < 4; k++)
        begin
            if (k == 3)
                apb(1'b1, `SEC_OFS_CTRL, 32'h0000_0010);
            tick <= 1'b1;
            @(posedge clk_i);
            tick <= 1'b0;
            // write a one to the done bit while a frame is being received
            if (k == 1)
            begin
                repeat (40) @(posedge clk_i);
                apb(1'b1, `SEC_OFS_CTRL, 32'h0000_1410);
                apb(1'b0, `SEC_OFS_CTRL, 32'h0000_0000);
                chk(r[`SEC_F_DONE], 1'b0);
            end
            repeat (200) @(posedge clk_i);
        end
        chk(frames - f, 3);
        $display("test repeat done");
    endtask
    task automatic t_irq();
        apb(1'b1, `SEC_OFS_MASK, 32'h0000_0003);
        mute <= 1'b1;
        frame(2'd2, 32'h0000_3010, 0, 16, 40'h00_0000_0000);
        apb(1'b0, `SEC_OFS_POS_HI, 32'h0000_0000);
        chk(r[`SEC_F_TOUT], 1'b1);
        apb(1'b0, `SEC_OFS_STAT, 32'h0000_0000);
        chk(r, 32'h0000_0003);
        chk(irq, 1'b1);
        apb(1'b1, `SEC_OFS_STAT, 32'h0000_0003);
        apb(1'b0, `SEC_OFS_STAT, 32'h0000_0000);
        chk(r, 32'h0000_0000);
        chk(irq, 1'b0);
        mute <= 1'b0;
        apb(1'b1, `SEC_OFS_MASK, 32'h0000_0000);
        frame(2'd2, 32'h0000_3010, 0, 16, 40'h00_0000_F00D);
        apb(1'b0, `SEC_OFS_STAT, 32'h0000_0000);
        chk(r, 32'h0000_0001);
        chk(irq, 1'b0);
        $display("test irq done");
    endtask
    initial
    begin
        repeat (5) @(posedge clk_i);
        rst_b_i <= 1'b1;
        @(posedge clk_i);
        t_reset();
        t_six();
        t_motor();
        t_biss();
        t_repeat();
        t_irq();
        end_sim();
    end
endmodule
